/* File: src/dcit_pkg.sv */
// Purpose: shared constants and types for the channel irq/trigger block
// Assumes: 16-bit register held in the low half of a 32-bit axi word
// Notes:   offsets are byte addresses
package dcit_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  IRQ_STATUS_OFFSET  = 8'h00;
   localparam logic [7:0]  CHANNEL_CTRL_OFFSET = 8'h04;
   localparam logic [7:0]  UPPER_LIMIT_OFFSET = 8'h08;
   localparam logic [7:0]  LOWER_LIMIT_OFFSET = 8'h0C;
   localparam logic [7:0]  START_COUNT_OFFSET = 8'h10;
   // ----------------------------------------------------------------
   // irq status field positions
   // ----------------------------------------------------------------
   localparam int PENDING_BIT   = 15;
   localparam int TRIG_SEL_LSB  = 8;
   localparam int TRIG_SEL_MSB  = 13;
   localparam int UPPER_BIT     = 7;
   localparam int LOWER_BIT     = 6;
   localparam int DONE_BIT      = 5;
   localparam int HALF_BIT      = 4;
   localparam int OVRUN_BIT     = 3;
   localparam int HALF_EN_BIT   = 0;
   localparam logic [15:0] IRQ_STATUS_WMASK = 16'h3FF9;
   localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;
   // control register fields
   localparam int CHAN_EN_BIT    = 0;
   localparam int DUMMY_MODE_BIT = 10;
   localparam logic [15:0] CHANNEL_CTRL_RESET = 16'h0000;
   localparam logic [15:0] UPPER_LIMIT_RESET  = 16'hFFFF;
   localparam logic [15:0] LOWER_LIMIT_RESET  = 16'h0800;
   localparam logic [15:0] START_COUNT_RESET  = 16'h0000;
   // ----------------------------------------------------------------
   // address space and trigger codes
   // ----------------------------------------------------------------
   localparam logic [15:0] SFR_TOP      = 16'h07FF;
   localparam logic [15:0] DATA_RAM_TOP = 16'h27FF;
   localparam logic [5:0]  TRIG_NONE    = 6'h00;
   localparam logic [5:0]  TRIG_CIPHER  = 6'h3F;
   localparam int          NUM_EVENTS   = 64;
   localparam int          NUM_CHANNELS = 6;
   localparam logic [1:0]  AXI_OKAY     = 2'h0;
   localparam logic [1:0]  AXI_SLVERR   = 2'h2;

   typedef enum logic [1:0] {
      WR_IDLE,
      WR_RESP
   } dcit_wr_state_type;
endpackage

/* File: src/dcit_limit_if.sv */
// Purpose: carries one checked access and its limit verdicts
// Assumes: same clock as the main module
// Notes:   one pair of flags per checker instance
`timescale 1ns/1ps
interface dcit_limit_if;
   logic        access;
   logic [15:0] addr;
   logic [15:0] upper;
   logic [15:0] lower;
   logic        above;
   logic        below;
   modport checker_end (input access, addr, upper, lower,
                        output above, below);
   modport user_end (output access, addr, upper, lower,
                     input above, below);
endinterface

/* File: src/dcit_limit_check.sv */
// Purpose: compares one completed access against the address limits
// Assumes: access has already been carried out
// Notes:   purely combinational
`timescale 1ns/1ps
module dcit_limit_check
   import dcit_pkg::*;
(
   dcit_limit_if.checker_end lim
);
   // ----------------------------------------------------------------
   // verdict
   // ----------------------------------------------------------------
   // checked after the fact, the access itself is never blocked
   always_comb begin
      lim.above = lim.access &&
                  ((lim.addr > lim.upper) || (lim.addr > DATA_RAM_TOP));
      lim.below = lim.access && (lim.addr < lim.lower) &&
                  (lim.addr > SFR_TOP);
   end
endmodule // dcit_limit_check

/* File: src/dcit_channel.sv */
// Purpose: per-channel status, trigger select and irq for a dma channel
// Assumes: transfer engine reports accesses, counts and session ends
// Notes:   registers reached over axi4-lite, 16 bits in the low half
//
// Overview of operation
// - pending flag high until buffered datum stored
// - six-bit trigger select at bits 13-8
// - fixed code map, zero none, chaining allowed
// - upper flag on access above limit/ram
// - lower flag below limit, above sfr range
// - enabled: done shows current session finished
// - disabled: done shows last session completed
// - halfway flag when count reaches midpoint
// - overrun flag on trigger while busy
// - halfway enable: irq at half and done
// - halfway disabled: irq only at done
// - software-written flags raise no irq
// - limits checked after access, not before
// - bits 14, 2, 1 read zero
// - dummy mode adds source write per dest
// - enable gates trigger response
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module dcit_channel
   import dcit_pkg::*;
(
   input  wire logic                 I_CLK,
   input  wire logic                 I_SYS_RST,
   input  wire logic [7:0]           I_AWADDR,
   input  wire logic                 I_AWVALID,
   output logic                      O_AWREADY,
   input  wire logic [31:0]          I_WDATA,
   input  wire logic [3:0]           I_WSTRB,
   input  wire logic                 I_WVALID,
   output logic                      O_WREADY,
   output logic [1:0]                O_BRESP,
   output logic                      O_BVALID,
   input  wire logic                 I_BREADY,
   input  wire logic [7:0]           I_ARADDR,
   input  wire logic                 I_ARVALID,
   output logic                      O_ARREADY,
   output logic [31:0]               O_RDATA,
   output logic [1:0]                O_RRESP,
   output logic                      O_RVALID,
   input  wire logic                 I_RREADY,
   input  wire logic [dcit_pkg::NUM_EVENTS-1:0]   I_EVENTS,
   input  wire logic [dcit_pkg::NUM_CHANNELS-1:0] I_CHAN_DONE,
   input  wire logic                 I_CIPHER_DONE,
   input  wire logic                 I_BUSY,
   input  wire logic                 I_SESSION_START,
   input  wire logic                 I_SESSION_END,
   input  wire logic                 I_SESSION_ABORT,
   input  wire logic                 I_ACCESS,
   input  wire logic [15:0]          I_SRC_ADDR,
   input  wire logic [15:0]          I_DST_ADDR,
   input  wire logic                 I_COUNT_WRITE,
   input  wire logic [15:0]          I_TRANSFER_COUNT,
   input  wire logic                 I_BUF_LOADED,
   input  wire logic                 I_BUF_STORED,
   output logic                      O_TRIGGER,
   output logic                      O_CHANNEL_ENABLE,
   output logic                      O_DUMMY_WRITE_MODE,
   output logic [5:0]                O_TRIGGER_SELECT,
   output logic                      O_CHANNEL_IRQ
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      dcit_wr_state_type wr_state;
      logic [7:0]        aw_addr;
      logic              aw_have;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              w_have;
      logic [1:0]        b_resp;
      logic              r_valid;
      logic [31:0]       r_data;
      logic [1:0]        r_resp;
      logic [15:0]       status;
      logic [15:0]       ctrl;
      logic [15:0]       upper_lim;
      logic [15:0]       lower_lim;
      logic [15:0]       start_cnt;
      logic              irq;
      logic              trig;
   } dcit_state_type;

   dcit_state_type s_q;
   dcit_state_type s_d;

   // ----------------------------------------------------------------
   // limit checkers
   // ----------------------------------------------------------------
   // one checker per pointer, both see the same limits
   dcit_limit_if src_lim ();
   dcit_limit_if dst_lim ();

   dcit_limit_check u_src_check (.lim(src_lim));
   dcit_limit_check u_dst_check (.lim(dst_lim));

   logic [NUM_EVENTS-1:0] ev_map;
   logic                  sel_event;
   logic                  wr_fire;
   logic [15:0]           wval;
   logic                  half_hit;
   logic [15:0]           half_mark;

   // ----------------------------------------------------------------
   // event map
   // ----------------------------------------------------------------
   always_comb begin
      // chained and cipher codes override the raw lines
      ev_map            = I_EVENTS;
      ev_map[TRIG_NONE] = 1'b0;
      ev_map[6'h38]     = I_CHAN_DONE[0];
      ev_map[6'h2E]     = I_CHAN_DONE[1];
      ev_map[6'h27]     = I_CHAN_DONE[2];
      ev_map[6'h1D]     = I_CHAN_DONE[3];
      ev_map[6'h14]     = I_CHAN_DONE[4];
      ev_map[6'h0F]     = I_CHAN_DONE[5];
      ev_map[TRIG_CIPHER] = I_CIPHER_DONE;
   end

   assign sel_event = ev_map[s_q.status[TRIG_SEL_MSB:TRIG_SEL_LSB]];

   // ----------------------------------------------------------------
   // limit checks
   // ----------------------------------------------------------------
   // source only matters when dummy writes go back to it
   always_comb begin
      src_lim.access = I_ACCESS && s_q.ctrl[DUMMY_MODE_BIT];
      src_lim.addr   = I_SRC_ADDR;
      src_lim.upper  = s_q.upper_lim;
      src_lim.lower  = s_q.lower_lim;
      dst_lim.access = I_ACCESS;
      dst_lim.addr   = I_DST_ADDR;
      dst_lim.upper  = s_q.upper_lim;
      dst_lim.lower  = s_q.lower_lim;
   end

   // ----------------------------------------------------------------
   // halfway watermark
   // ----------------------------------------------------------------
   // midpoint of start value and zero
   // odd start counts round the midpoint down
   assign half_mark = {1'b0, s_q.start_cnt[15:1]};
   assign half_hit  = I_COUNT_WRITE && (I_TRANSFER_COUNT == half_mark)
                      && (s_q.start_cnt != 16'h0000);

   assign wr_fire = s_q.aw_have && s_q.w_have && s_q.wr_state == WR_IDLE;
   assign wval    = s_q.w_data[15:0];

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      s_d.trig = 1'b0;
      s_d.irq  = 1'b0;
      // ----------------------------------------------------------------
      // register bus write
      // ----------------------------------------------------------------
      // write channel: address and data taken in either order
      if (I_AWVALID && !s_q.aw_have && s_q.wr_state == WR_IDLE) begin
         s_d.aw_addr = I_AWADDR;
         s_d.aw_have = 1'b1;
      end
      if (I_WVALID && !s_q.w_have && s_q.wr_state == WR_IDLE) begin
         s_d.w_data = I_WDATA;
         s_d.w_strb = I_WSTRB;
         s_d.w_have = 1'b1;
      end
      // software writes first, hardware sets below win over them
      if (wr_fire) begin
         s_d.aw_have  = 1'b0;
         s_d.w_have   = 1'b0;
         s_d.wr_state = WR_RESP;
         s_d.b_resp   = AXI_OKAY;
         case (s_q.aw_addr)
            IRQ_STATUS_OFFSET: begin
               // stored only, the irq path sees hardware events only
               if (s_q.w_strb[0])
                  s_d.status[7:0] = (wval[7:0] & IRQ_STATUS_WMASK[7:0])
                     | (s_q.status[7:0] & ~IRQ_STATUS_WMASK[7:0]);
               if (s_q.w_strb[1])
                  s_d.status[15:8] = (wval[15:8] & IRQ_STATUS_WMASK[15:8])
                     | (s_q.status[15:8] & ~IRQ_STATUS_WMASK[15:8]);
            end
            CHANNEL_CTRL_OFFSET: begin
               if (s_q.w_strb[0]) s_d.ctrl[7:0] = wval[7:0];
               if (s_q.w_strb[1]) s_d.ctrl[15:8] = wval[15:8];
            end
            UPPER_LIMIT_OFFSET: begin
               if (s_q.w_strb[0]) s_d.upper_lim[7:0] = wval[7:0];
               if (s_q.w_strb[1]) s_d.upper_lim[15:8] = wval[15:8];
            end
            LOWER_LIMIT_OFFSET: begin
               if (s_q.w_strb[0]) s_d.lower_lim[7:0] = wval[7:0];
               if (s_q.w_strb[1]) s_d.lower_lim[15:8] = wval[15:8];
            end
            START_COUNT_OFFSET: begin
               if (s_q.w_strb[0]) s_d.start_cnt[7:0] = wval[7:0];
               if (s_q.w_strb[1]) s_d.start_cnt[15:8] = wval[15:8];
            end
            default: s_d.b_resp = AXI_SLVERR;
         endcase
      end
      case (s_q.wr_state)
         WR_IDLE: ;
         WR_RESP: if (I_BREADY) s_d.wr_state = WR_IDLE;
         default: s_d.wr_state = WR_IDLE;
      endcase
      // ----------------------------------------------------------------
      // register bus read
      // ----------------------------------------------------------------
      // one read at a time, arready low while a reply waits
      if (s_q.r_valid && I_RREADY)
         s_d.r_valid = 1'b0;
      if (I_ARVALID && !s_q.r_valid) begin
         s_d.r_valid = 1'b1;
         s_d.r_resp  = AXI_OKAY;
         s_d.r_data  = 32'h0000_0000;
         case (I_ARADDR)
            IRQ_STATUS_OFFSET:   s_d.r_data[15:0] = s_q.status;
            CHANNEL_CTRL_OFFSET: s_d.r_data[15:0] = s_q.ctrl;
            UPPER_LIMIT_OFFSET:  s_d.r_data[15:0] = s_q.upper_lim;
            LOWER_LIMIT_OFFSET:  s_d.r_data[15:0] = s_q.lower_lim;
            START_COUNT_OFFSET:  s_d.r_data[15:0] = s_q.start_cnt;
            default:             s_d.r_resp = AXI_SLVERR;
         endcase
      end
      // ----------------------------------------------------------------
      // hardware flag updates, set wins over software clear
      // ----------------------------------------------------------------
      // load wins, so a datum taken as another lands stays flagged
      if (s_q.ctrl[DUMMY_MODE_BIT]) begin
         if (I_BUF_LOADED) s_d.status[PENDING_BIT] = 1'b1;
         else if (I_BUF_STORED) s_d.status[PENDING_BIT] = 1'b0;
      end else begin
         s_d.status[PENDING_BIT] = 1'b0;
      end
      if (src_lim.above || dst_lim.above)
         s_d.status[UPPER_BIT] = 1'b1;
      if (src_lim.below || dst_lim.below)
         s_d.status[LOWER_BIT] = 1'b1;
      if (s_q.ctrl[CHAN_EN_BIT] && I_SESSION_START)
         s_d.status[DONE_BIT] = 1'b0;
      // an end in the same cycle still wins
      if (I_SESSION_ABORT)
         s_d.status[DONE_BIT] = 1'b0;
      if (I_SESSION_END) begin
         s_d.status[DONE_BIT] = 1'b1;
         s_d.irq = 1'b1;
      end
      if (half_hit) begin
         s_d.status[HALF_BIT] = 1'b1;
         if (s_q.status[HALF_EN_BIT]) s_d.irq = 1'b1;
      end
      // overrun counts only triggers the channel accepts
      if (s_q.ctrl[CHAN_EN_BIT] && sel_event) begin
         s_d.trig = 1'b1;
         if (I_BUSY) s_d.status[OVRUN_BIT] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         s_q           <= '0;
         s_q.wr_state  <= WR_IDLE;
         s_q.status    <= IRQ_STATUS_RESET;
         s_q.ctrl      <= CHANNEL_CTRL_RESET;
         s_q.upper_lim <= UPPER_LIMIT_RESET;
         s_q.lower_lim <= LOWER_LIMIT_RESET;
         s_q.start_cnt <= START_COUNT_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // readies combinational, so a master waits only while a held word or a reply is pending
   assign O_AWREADY = !s_q.aw_have && s_q.wr_state == WR_IDLE;
   assign O_WREADY  = !s_q.w_have && s_q.wr_state == WR_IDLE;
   assign O_BVALID  = s_q.wr_state == WR_RESP;
   assign O_BRESP   = s_q.b_resp;
   assign O_ARREADY = !s_q.r_valid;
   assign O_RVALID  = s_q.r_valid;
   assign O_RDATA   = s_q.r_data;
   assign O_RRESP   = s_q.r_resp;
   // ----------------------------------------------------------------
   // channel outputs
   // ----------------------------------------------------------------
   assign O_TRIGGER = s_q.trig;
   assign O_CHANNEL_ENABLE   = s_q.ctrl[CHAN_EN_BIT];
   assign O_DUMMY_WRITE_MODE = s_q.ctrl[DUMMY_MODE_BIT];
   assign O_TRIGGER_SELECT   = s_q.status[TRIG_SEL_MSB:TRIG_SEL_LSB];
   assign O_CHANNEL_IRQ      = s_q.irq;
endmodule // dcit_channel

/* File: tb/dcit_channel_monitor.sv */
// Purpose: port checks for the channel irq/trigger block
// Assumes: one clock, synchronous active-high reset
// Notes:   rd_st_q marks a read of the status word
`timescale 1ns/1ps
module dcit_channel_monitor
   import dcit_pkg::*;
(
   input wire logic                               I_CLK,
   input wire logic                               I_SYS_RST,
   input wire logic [7:0]                         I_ARADDR,
   input wire logic                               I_ARVALID,
   input wire logic                               O_ARREADY,
   input wire logic [31:0]                        O_RDATA,
   input wire logic                               O_RVALID,
   input wire logic                               I_RREADY,
   input wire logic [dcit_pkg::NUM_EVENTS-1:0]    I_EVENTS,
   input wire logic [dcit_pkg::NUM_CHANNELS-1:0]  I_CHAN_DONE,
   input wire logic                               I_CIPHER_DONE,
   input wire logic                               I_SESSION_END,
   input wire logic                               O_TRIGGER,
   input wire logic                               O_CHANNEL_ENABLE,
   input wire logic [5:0]                         O_TRIGGER_SELECT,
   input wire logic                               O_CHANNEL_IRQ
);
   logic rd_st_q;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST)
         rd_st_q <= 1'b0;
      else if (I_ARVALID && O_ARREADY)
         rd_st_q <= (I_ARADDR == IRQ_STATUS_OFFSET);
   end
   sequence sel_on(c);
      O_CHANNEL_ENABLE && (O_TRIGGER_SELECT == c);
   endsequence
   reset_clear_a: assert property ($fell(I_SYS_RST) |-> !O_TRIGGER &&
      !O_CHANNEL_IRQ && !O_CHANNEL_ENABLE && O_TRIGGER_SELECT == 6'h00)
      else $error("outputs not cleared by reset");
   plain_trig_a: assert property (sel_on(6'h01) ##0 I_EVENTS[1]
      |=> O_TRIGGER) else $error("selected event gave no trigger");
   cipher_trig_a: assert property (sel_on(TRIG_CIPHER) ##0 I_CIPHER_DONE
      |=> O_TRIGGER) else $error("cipher done gave no trigger");
   chain_trig_a: assert property (sel_on(6'h38) ##0 I_CHAN_DONE[0]
      |=> O_TRIGGER) else $error("chained done gave no trigger");
   none_trig_a: assert property (O_TRIGGER_SELECT == TRIG_NONE
      |=> !O_TRIGGER) else $error("trigger with no source selected");
   gate_trig_a: assert property (!O_CHANNEL_ENABLE |=> !O_TRIGGER)
      else $error("trigger while channel disabled");
   done_irq_a: assert property (O_CHANNEL_ENABLE && I_SESSION_END
      |=> O_CHANNEL_IRQ) else $error("no irq at session end");
   unimpl_zero_a: assert property (O_RVALID && rd_st_q |->
      O_RDATA[14] == 1'b0 && O_RDATA[2:1] == 2'b00)
      else $error("unimplemented status bits read nonzero");
   read_hold_a: assert property (O_RVALID && !I_RREADY |=>
      O_RVALID && $stable(O_RDATA)) else $error("read answer dropped");
endmodule // dcit_channel_monitor

bind dcit_channel dcit_channel_monitor i_mon (.I_CLK(I_CLK),
   .I_SYS_RST(I_SYS_RST), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
   .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
   .I_RREADY(I_RREADY), .I_EVENTS(I_EVENTS), .I_CHAN_DONE(I_CHAN_DONE),
   .I_CIPHER_DONE(I_CIPHER_DONE), .I_SESSION_END(I_SESSION_END),
   .O_TRIGGER(O_TRIGGER), .O_CHANNEL_ENABLE(O_CHANNEL_ENABLE),
   .O_TRIGGER_SELECT(O_TRIGGER_SELECT), .O_CHANNEL_IRQ(O_CHANNEL_IRQ));

/* File: tb/dcit_engine_model.sv */
// Purpose: behavioural transfer engine behind one channel
// Assumes: one session per trigger, count runs down to zero
// Notes:   a trigger while busy is dropped, as in the real engine
`timescale 1ns/1ps
module dcit_engine_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        trig,
   input  wire logic        abort_req,
   input  wire logic        dummy,
   input  wire logic [15:0] len,
   output logic             busy,
   output logic             start,
   output logic             done,
   output logic             abort,
   output logic             access,
   output logic             cnt_wr,
   output logic [15:0]      cnt,
   output logic             buf_ld,
   output logic             buf_st
);
   always_ff @(posedge clk) begin
      start  <= 1'b0;
      done   <= 1'b0;
      abort  <= 1'b0;
      access <= 1'b0;
      cnt_wr <= 1'b0;
      buf_ld <= 1'b0;
      buf_st <= buf_ld & ~rst; // datum lands a cycle after it is taken
      if (rst) begin
         busy <= 1'b0;
      end else if (abort_req && busy) begin
         busy  <= 1'b0;
         abort <= 1'b1;
      end else if (trig && !busy) begin
         busy   <= 1'b1;
         start  <= 1'b1;
         cnt_wr <= 1'b1;
         cnt    <= len;
      end else if (busy) begin
         access <= 1'b1; // carried out before any limit verdict
         buf_ld <= dummy; // one dummy source write per dest write
         cnt_wr <= 1'b1;
         cnt    <= cnt - 16'h0001;
         busy   <= (cnt != 16'h0001);
         done   <= (cnt == 16'h0001);
      end
   end
endmodule // dcit_engine_model

/* File: tb/dcit_channel_tb.sv */
// Purpose: self-checking bench for the channel irq/trigger block
// Assumes: 10 MHz clock, synchronous high reset held 4 cycles
// Notes:   expectations come from bench functions and constants only
`timescale 1ns/1ps
module dcit_channel_tb;
   import dcit_pkg::*;
   logic        clk, rst, awv, wv, bry, arv, rry, ciph, abrt;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rd_v;
   logic [63:0] ev;
   logic [5:0]  chd, code;
   logic [15:0] len, addr;
   logic [1:0]  rr;
   wire         awr, wrd, bv, arr, rv, trg, en, dm, irq, busy, ss, se;
   wire         sa, acc, cw, bl, bs;
   wire  [1:0]  br, rsp;
   wire  [31:0] rdat;
   wire  [5:0]  sel;
   wire  [15:0] cnt;
   int          fails, cmp_count, cyc, trg_n, irq_n, t0, i0;
   integer      seed;
   logic [5:0]  chn [6] = '{6'h38, 6'h2E, 6'h27, 6'h1D, 6'h14, 6'h0F};
   logic [15:0] rst_v [5] = '{IRQ_STATUS_RESET, CHANNEL_CTRL_RESET,
      UPPER_LIMIT_RESET, LOWER_LIMIT_RESET, START_COUNT_RESET};
   logic [15:0] lim_a [3] = '{16'h2100, 16'h0900, 16'h0700};
   logic [31:0] lim_f [3] = '{32'h80, 32'h40, 32'h00};
   dcit_channel i_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_AWADDR(awa),
      .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'h3),
      .I_WVALID(wv), .O_WREADY(wrd), .O_BRESP(br), .O_BVALID(bv),
      .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
      .O_RDATA(rdat), .O_RRESP(rsp), .O_RVALID(rv), .I_RREADY(rry),
      .I_EVENTS(ev), .I_CHAN_DONE(chd), .I_CIPHER_DONE(ciph),
      .I_BUSY(busy), .I_SESSION_START(ss), .I_SESSION_END(se),
      .I_SESSION_ABORT(sa), .I_ACCESS(acc), .I_SRC_ADDR(addr),
      .I_DST_ADDR(addr), .I_COUNT_WRITE(cw), .I_TRANSFER_COUNT(cnt),
      .I_BUF_LOADED(bl), .I_BUF_STORED(bs), .O_TRIGGER(trg),
      .O_CHANNEL_ENABLE(en), .O_DUMMY_WRITE_MODE(dm),
      .O_TRIGGER_SELECT(sel), .O_CHANNEL_IRQ(irq));
   dcit_engine_model i_eng (.clk(clk), .rst(rst), .trig(trg),
      .abort_req(abrt), .dummy(dm), .len(len), .busy(busy), .start(ss),
      .done(se), .abort(sa), .access(acc), .cnt_wr(cw), .cnt(cnt),
      .buf_ld(bl), .buf_st(bs));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      trg_n <= trg_n + int'(trg === 1'b1);
      irq_n <= irq_n + int'(irq === 1'b1);
      if (cyc > 5000) begin
         fails++;
         tally_and_finish();
      end
   end
   function automatic logic [31:0] exp_st(logic [5:0] c, logic h, logic r);
      return {18'h0, c, 2'b00, r, r, 3'b000, h};
   endfunction
   function automatic logic [31:0] exp_irq(logic h, logic r);
      return r ? (h ? 32'h2 : 32'h1) : 32'h0;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t saw %h want %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge clk);
      awa <= a;
      wd <= {16'h0000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
         ad = ad | awr;
         dd = dd | wrd;
      end
      while (!bv) @(posedge clk);
      bry <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      do @(posedge clk); while (!rv);
      rd_v = rdat;
      rr = rsp;
      rry <= 1'b0;
   endtask
   task automatic fire(input logic [5:0] c);
      logic hit;
      hit = (c == TRIG_CIPHER);
      @(posedge clk);
      for (int k = 0; k < 6; k++) begin
         chd[k] <= (c == chn[k]);
         hit = hit | (c == chn[k]);
      end
      ciph <= (c == TRIG_CIPHER);
      if (!hit) ev[c] <= 1'b1;
      @(posedge clk);
      ev <= 64'h0;
      chd <= 6'h00;
      ciph <= 1'b0;
   endtask
   task automatic settle();
      repeat (2) @(posedge clk);
      while (busy) @(posedge clk);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      seed = 32'h836769cc;
      rst = 1'b1;
      {awv, wv, bry, arv, rry, ciph, abrt} = 7'h00;
      {awa, ara} = 16'h0000;
      wd = 32'h0;
      ev = 64'h0;
      chd = 6'h00;
      len = 16'h0004;
      addr = 16'h1000;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 5; k++) begin
         rd(8'(k * 4));
         chk(rd_v, {16'h0000, rst_v[k]});
      end
      rd(8'h14);
      chk({rd_v[31:2], rr}, {30'h0, AXI_SLVERR});
      wr(IRQ_STATUS_OFFSET, 16'hFFFF);
      rd(IRQ_STATUS_OFFSET);
      chk(rd_v, 32'h3FF9);
      chk(32'(irq_n), 32'h0);
      wr(IRQ_STATUS_OFFSET, 16'h0000);
      rd(IRQ_STATUS_OFFSET);
      chk(rd_v, 32'h0);
      $display("reset and status access done");
      wr(START_COUNT_OFFSET, 16'h0004);
      wr(CHANNEL_CTRL_OFFSET, 16'h0001);
      for (int i = 0; i < 9; i++) begin
         code = (i < 6) ? chn[i] : (i == 6) ? TRIG_CIPHER : TRIG_NONE;
         if (i == 7) code = 6'({$random(seed)} % 13 + 1);
         t0 = trg_n;
         i0 = irq_n;
         wr(IRQ_STATUS_OFFSET, {2'b00, code, 7'h00, i[0]});
         fire(code);
         settle();
         rd(IRQ_STATUS_OFFSET);
         chk(rd_v, exp_st(code, i[0], code != TRIG_NONE));
         chk(32'(trg_n - t0), 32'(code != TRIG_NONE));
         chk(32'(irq_n - i0), exp_irq(i[0], code != TRIG_NONE));
      end
      $display("trigger codes done");
      wr(IRQ_STATUS_OFFSET, 16'h0100);
      fire(6'h01);
      fire(6'h01);
      settle();
      rd(IRQ_STATUS_OFFSET);
      chk(rd_v & 32'h8, 32'h8);
      wr(UPPER_LIMIT_OFFSET, 16'h2000);
      wr(LOWER_LIMIT_OFFSET, 16'h1000);
      for (int k = 0; k < 3; k++) begin
         addr <= lim_a[k];
         wr(IRQ_STATUS_OFFSET, 16'h0100);
         fire(6'h01);
         settle();
         rd(IRQ_STATUS_OFFSET);
         chk(rd_v & 32'hC0, lim_f[k]);
      end
      $display("overrun and limits done");
      wr(CHANNEL_CTRL_OFFSET, 16'h0000);
      rd(IRQ_STATUS_OFFSET);
      chk(rd_v & 32'h20, 32'h20);
      t0 = trg_n;
      fire(6'h01);
      settle();
      chk(32'(trg_n - t0), 32'h0);
      len <= 16'h0020;
      wr(CHANNEL_CTRL_OFFSET, 16'h0001);
      fire(6'h01);
      repeat (2) @(posedge clk);
      rd(IRQ_STATUS_OFFSET);
      chk(rd_v & 32'h20, 32'h0);
      abrt <= 1'b1;
      @(posedge clk);
      abrt <= 1'b0;
      wr(CHANNEL_CTRL_OFFSET, 16'h0000);
      rd(IRQ_STATUS_OFFSET);
      chk(rd_v & 32'h20, 32'h0);
      len <= 16'h0004;
      wr(CHANNEL_CTRL_OFFSET, 16'h0401);
      chk({31'h0, dm}, 32'h1);
      fire(6'h01);
      repeat (2) @(posedge clk);
      rd(IRQ_STATUS_OFFSET);
      chk(rd_v & 32'h8000, 32'h8000);
      settle();
      rd(IRQ_STATUS_OFFSET);
      chk(rd_v & 32'h8000, 32'h0);
      $display("enable, abort and dummy mode done");
      tally_and_finish();
   end
endmodule // dcit_channel_tb
